// >>> arcbp_pkg.sv
package arcbp_pkg;

    // Register port
    localparam int unsigned REG_ADDR_W        = 9;
    localparam int unsigned REG_DATA_W        = 8;
    localparam logic [8:0]  PHY_ADDR_OFS      = 9'h06c;
    localparam logic [7:0]  PHY_ADDR_RST      = 8'h00;
    localparam logic [7:0]  UNMAPPED_RDATA    = 8'h00;

    // Cell bus
    localparam int unsigned BUS_W             = 16;
    localparam int unsigned BYTE_W            = 8;
    localparam int unsigned PHY_ADDR_W        = 5;
    localparam int unsigned BUS_CLK_MAX_MHZ   = 50;
    localparam logic        PARITY_RST        = 1'b1;
    localparam logic [15:0] WORD_RST          = 16'h0000;

    // Queue geometry
    localparam int unsigned QUEUE_W           = 17;
    localparam int unsigned QUEUE_AW          = 10;
    localparam int unsigned PTR_W             = 11;
    localparam logic [10:0] QUEUE_DEPTH       = 11'h400;
    localparam int unsigned FIRST_BIT         = 16;

    // Cell length in bus transfers
    localparam logic [10:0] CELL_WORDS_WIDE   = 11'h01b;
    localparam logic [10:0] CELL_BYTES_NARROW = 11'h035;

    // Config bundle positions
    localparam int unsigned CFG_W             = 8;
    localparam int unsigned CFG_WIDE_BIT      = 5;
    localparam int unsigned CFG_CELL_BIT      = 6;
    localparam int unsigned CFG_MULTI_BIT     = 7;

    function automatic logic [10:0] bin2gray(input logic [10:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [10:0] gray2bin(input logic [10:0] g);
        logic [10:0] b;
        b     = '0;
        b[10] = g[10];
        for (int i = 9; i >= 0; i--)
        begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    function automatic logic odd_parity(input logic [15:0] w, input logic wide);
        return wide ? ~(^w) : ~(^w[7:0]);
    endfunction : odd_parity

endpackage : arcbp_pkg

// >>> arcbp_sync.sv
`timescale 1ns/10ps
module arcbp_sync #(
    parameter int unsigned W = 1
) (
    // Destination clock
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // Level in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } arcbp_sync_s;

    arcbp_sync_s state_reg;
    arcbp_sync_s state_next;

    always_comb
    begin
        state_next.meta = d_i;
        state_next.held = state_reg.meta;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign q_o = state_reg.held;
endmodule : arcbp_sync

// >>> arcbp_queue.sv
`timescale 1ns/10ps
module arcbp_queue (
    // Line side
    input  wire logic        wr_clk_i,
    input  wire logic        wr_rst_b_i,
    input  wire logic        wr_valid_i,
    output logic             wr_ready_o,
    input  wire logic [16:0] wr_data_i,
    // Cell bus side
    input  wire logic        rd_clk_i,
    input  wire logic        rd_rst_b_i,
    input  wire logic        rd_pop_i,
    output logic      [16:0] rd_head_o,
    output logic             rd_empty_o,
    output logic      [10:0] rd_level_o
);
    typedef struct packed {
        logic [10:0] bin;
        logic [10:0] gray;
    } arcbp_ptr_s;

    logic [16:0] mem [0:1023];
    arcbp_ptr_s  wr_reg;
    arcbp_ptr_s  wr_next;
    arcbp_ptr_s  rd_reg;
    arcbp_ptr_s  rd_next;
    logic [10:0] rgray_at_wr;
    logic [10:0] wgray_at_rd;
    logic [10:0] used_wr;
    logic        push;
    logic        pop;

    // Gray pointers cross each way
    arcbp_sync #(.W(arcbp_pkg::PTR_W)) u_rptr_sync (
        .clk_i   (wr_clk_i),
        .rst_b_i (wr_rst_b_i),
        .d_i     (rd_reg.gray),
        .q_o     (rgray_at_wr)
    ); // [R14]

    arcbp_sync #(.W(arcbp_pkg::PTR_W)) u_wptr_sync (
        .clk_i   (rd_clk_i),
        .rst_b_i (rd_rst_b_i),
        .d_i     (wr_reg.gray),
        .q_o     (wgray_at_rd)
    ); // [R14]

    assign used_wr    = wr_reg.bin - arcbp_pkg::gray2bin(rgray_at_wr);
    assign wr_ready_o = (used_wr != arcbp_pkg::QUEUE_DEPTH);
    assign push       = wr_valid_i & wr_ready_o;
    assign rd_level_o = arcbp_pkg::gray2bin(wgray_at_rd) - rd_reg.bin;
    assign rd_empty_o = (rd_level_o == '0);
    assign pop        = rd_pop_i & ~rd_empty_o; // [R15]
    assign rd_head_o  = mem[rd_reg.bin[9:0]];

    always_comb
    begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (push)
        begin
            wr_next.bin  = wr_reg.bin + 11'h001;
            wr_next.gray = arcbp_pkg::bin2gray(wr_next.bin);
        end
        if (pop)
        begin
            rd_next.bin  = rd_reg.bin + 11'h001;
            rd_next.gray = arcbp_pkg::bin2gray(rd_next.bin);
        end
    end

    always_ff @(posedge wr_clk_i)
    begin
        if (push)
            mem[wr_reg.bin[9:0]] <= wr_data_i;
    end

    always_ff @(posedge wr_clk_i or negedge wr_rst_b_i)
    begin
        if (!wr_rst_b_i)
            wr_reg <= '0;
        else
            wr_reg <= wr_next;
    end

    always_ff @(posedge rd_clk_i or negedge rd_rst_b_i)
    begin
        if (!rd_rst_b_i)
            rd_reg <= '0;
        else
            rd_reg <= rd_next;
    end
endmodule : arcbp_queue

// >>> arcbp_top.sv
// How it works
// [R1] Bus word changes on rising edge of the cell bus clock, up to 50 MHz.
// [R2] Cells leave on a 16-bit word bus, byte or word per transfer.
// [R3] First-word flag is high while a cell's first byte or word is out.
// [R4] Odd parity of each driven byte or word stands beside it.
// [R5] Read enable is active low; while high the word bus floats.
// [R6] Enable low pops the queue head onto the bus at the next edge.
// [R7] Octet mode: cell available high while any byte is queued.
// [R8] Cell mode: cell available high only with a whole cell queued.
// [R9] PHY address is sampled each bus clock edge, used only in multi-PHY.
// [R10] Address matching register 6Ch drives cell available; mismatch leaves it floating.
// [R11] Multi-PHY: float until cycle after a match, then follow cell mode.
// [R12] One accepted pulse for every new cell taken into the queue.
// [R13] Narrow bus: one byte on low bits, upper bits unused and unparitied.
// [R14] Words cross line clock to bus clock through the queue, gray pointers.
// [R15] Empty queue is never popped; bus word then holds its value.
`timescale 1ns/10ps
module arcbp_top (
    // System clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // Register port
    input  wire logic        reg_select_i,
    input  wire logic        reg_write_i,
    input  wire logic [8:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // Static configuration
    input  wire logic        bus_wide_i,
    input  wire logic        cell_level_mode_i,
    input  wire logic        multi_phy_i,
    // Cells from the receive cell processor
    input  wire logic [15:0] cell_word_i,
    input  wire logic        cell_word_first_i,
    input  wire logic        cell_word_valid_i,
    output logic             cell_word_ready_o,
    output logic             cell_accepted_pulse_o,
    // Cell bus to the ATM layer
    input  wire logic        rx_cell_bus_clock_i,
    input  wire logic        rx_cell_bus_read_enable_n_i,
    input  wire logic [4:0]  rx_phy_select_address_i,
    output logic      [15:0] rx_cell_bus_word_o,
    output logic             rx_cell_bus_word_oe_o,
    output logic             rx_cell_first_word_flag_o,
    output logic             rx_cell_bus_odd_parity_o,
    output logic             rx_cell_available_o,
    output logic             rx_cell_available_oe_o
);
    typedef struct packed {
        logic [7:0] phy_addr;
        logic [7:0] rdata;
        logic       accepted;
    } arcbp_sys_s;

    typedef struct packed {
        logic [4:0]  addr_seen;
        logic [15:0] word;
        logic        first;
        logic        parity;
        logic        drive;
    } arcbp_bus_s;

    arcbp_sys_s  sys_reg;
    arcbp_sys_s  sys_next;
    arcbp_bus_s  bus_reg;
    arcbp_bus_s  bus_next;

    logic        bus_rst_b;
    logic [7:0]  cfg_sys;
    logic [7:0]  cfg_bus;
    logic        wide_bus;
    logic        cell_mode_bus;
    logic        multi_bus;
    logic        push_ok;
    logic [16:0] queue_in;
    logic [16:0] queue_head;
    logic        queue_empty;
    logic [10:0] queue_level;
    logic        pop_req;
    logic        popped;
    logic [10:0] cell_len;
    logic        whole_cell;
    logic        addr_match;

    // Bus domain reset release
    arcbp_sync #(.W(1)) u_rst_sync (
        .clk_i   (rx_cell_bus_clock_i),
        .rst_b_i (rst_b_i),
        .d_i     (1'b1),
        .q_o     (bus_rst_b)
    );

    // Quasi-static settings into bus domain
    assign cfg_sys = {multi_phy_i, cell_level_mode_i, bus_wide_i,
                      sys_reg.phy_addr[arcbp_pkg::PHY_ADDR_W-1:0]};

    arcbp_sync #(.W(arcbp_pkg::CFG_W)) u_cfg_sync (
        .clk_i   (rx_cell_bus_clock_i),
        .rst_b_i (bus_rst_b),
        .d_i     (cfg_sys),
        .q_o     (cfg_bus)
    );

    assign wide_bus      = cfg_bus[arcbp_pkg::CFG_WIDE_BIT];
    assign cell_mode_bus = cfg_bus[arcbp_pkg::CFG_CELL_BIT];
    assign multi_bus     = cfg_bus[arcbp_pkg::CFG_MULTI_BIT];

    // Line side push
    assign push_ok  = cell_word_valid_i & cell_word_ready_o;
    assign queue_in = {cell_word_first_i,
                       bus_wide_i ? cell_word_i : {8'h00, cell_word_i[7:0]}}; // [R13]

    arcbp_queue u_queue (
        .wr_clk_i   (clk_sys_i),
        .wr_rst_b_i (rst_b_i),
        .wr_valid_i (cell_word_valid_i),
        .wr_ready_o (cell_word_ready_o),
        .wr_data_i  (queue_in),
        .rd_clk_i   (rx_cell_bus_clock_i),
        .rd_rst_b_i (bus_rst_b),
        .rd_pop_i   (pop_req),
        .rd_head_o  (queue_head),
        .rd_empty_o (queue_empty),
        .rd_level_o (queue_level)
    ); // [R14]

    // System domain: register and accepted pulse
    always_comb
    begin
        sys_next          = sys_reg;
        sys_next.accepted = push_ok & cell_word_first_i; // [R12]
        sys_next.rdata    = arcbp_pkg::UNMAPPED_RDATA;
        if (reg_select_i && (reg_addr_i == arcbp_pkg::PHY_ADDR_OFS))
        begin
            if (reg_write_i)
                sys_next.phy_addr = reg_wdata_i; // [R10]
            else
                sys_next.rdata = sys_reg.phy_addr;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sys_reg.phy_addr <= arcbp_pkg::PHY_ADDR_RST;
            sys_reg.rdata    <= arcbp_pkg::UNMAPPED_RDATA;
            sys_reg.accepted <= 1'b0;
        end
        else
            sys_reg <= sys_next;
    end

    assign reg_rdata_o           = sys_reg.rdata;
    assign cell_accepted_pulse_o = sys_reg.accepted;

    // Bus domain: pop, word, flag, parity
    assign pop_req = ~rx_cell_bus_read_enable_n_i; // [R6]
    assign popped  = pop_req & ~queue_empty; // [R15]

    always_comb
    begin
        bus_next           = bus_reg;
        bus_next.addr_seen = rx_phy_select_address_i; // [R9]
        bus_next.drive     = pop_req; // [R5]
        if (popped)
        begin
            bus_next.word   = wide_bus ? queue_head[15:0] : {8'h00, queue_head[7:0]}; // [R1] [R2] [R13]
            bus_next.first  = queue_head[arcbp_pkg::FIRST_BIT]; // [R3]
            bus_next.parity = arcbp_pkg::odd_parity(queue_head[15:0], wide_bus); // [R4] [R13]
        end
    end

    always_ff @(posedge rx_cell_bus_clock_i or negedge bus_rst_b)
    begin
        if (!bus_rst_b)
        begin
            bus_reg.addr_seen <= '0;
            bus_reg.word      <= arcbp_pkg::WORD_RST;
            bus_reg.first     <= 1'b0;
            bus_reg.parity    <= arcbp_pkg::PARITY_RST;
            bus_reg.drive     <= 1'b0;
        end
        else
            bus_reg <= bus_next;
    end

    assign rx_cell_bus_word_o        = bus_reg.word;
    assign rx_cell_bus_word_oe_o     = bus_reg.drive; // [R5]
    assign rx_cell_first_word_flag_o = bus_reg.first;
    assign rx_cell_bus_odd_parity_o  = bus_reg.parity;

    // Cell available
    assign cell_len   = wide_bus ? arcbp_pkg::CELL_WORDS_WIDE : arcbp_pkg::CELL_BYTES_NARROW;
    assign whole_cell = (queue_level >= cell_len); // [R8]
    assign addr_match = (bus_reg.addr_seen == cfg_bus[arcbp_pkg::PHY_ADDR_W-1:0]); // [R10]

    always_comb
    begin
        if (multi_bus)
        begin
            rx_cell_available_o    = whole_cell; // [R11]
            rx_cell_available_oe_o = addr_match; // [R10] [R11]
        end
        else
        begin
            rx_cell_available_o    = cell_mode_bus ? whole_cell : ~queue_empty; // [R7] [R8]
            rx_cell_available_oe_o = 1'b1;
        end
    end
endmodule : arcbp_top

// >>> arcbp_monitor.sv
`timescale 1ns/10ps
module arcbp_chk (
    // Clocks and register port
    input wire logic        clk_sys_i, rst_b_i, rx_cell_bus_clock_i,
    input wire logic        reg_select_i, reg_write_i,
    input wire logic [8:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i, reg_rdata_o,
    // Cell side
    input wire logic        bus_wide_i, multi_phy_i, cell_word_first_i,
    input wire logic        cell_word_valid_i, cell_word_ready_o, cell_accepted_pulse_o,
    // Cell bus
    input wire logic        rx_cell_bus_read_enable_n_i, rx_cell_bus_word_oe_o,
    input wire logic        rx_cell_first_word_flag_o, rx_cell_bus_odd_parity_o, rx_cell_available_oe_o,
    input wire logic [4:0]  rx_phy_select_address_i,
    input wire logic [15:0] rx_cell_bus_word_o
);
    logic [7:0] shd_reg;
    logic [2:0] age_reg;
    logic       rd_map;
    wire        bc = rx_cell_bus_clock_i;
    assign rd_map = reg_select_i & ~reg_write_i & (reg_addr_i == arcbp_pkg::PHY_ADDR_OFS);
    // Shadow of the address register
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
        if (!rst_b_i)
            shd_reg <= arcbp_pkg::PHY_ADDR_RST;
        else if (reg_select_i & reg_write_i & (reg_addr_i == arcbp_pkg::PHY_ADDR_OFS))
            shd_reg <= reg_wdata_i;
    // Bus edges since reset
    always_ff @(posedge bc or negedge rst_b_i)
        if (!rst_b_i)
            age_reg <= 3'h0;
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
    property p_oe; @(posedge bc) disable iff (!rst_b_i)
        rx_cell_bus_word_oe_o == !$past(rx_cell_bus_read_enable_n_i); endproperty
    a_oe: assert property (p_oe) else $error("data enable wrong");
    property p_par; @(posedge bc) disable iff (!rst_b_i)
        ^{bus_wide_i ? rx_cell_bus_word_o[15:8] : 8'h00, rx_cell_bus_word_o[7:0], rx_cell_bus_odd_parity_o};
    endproperty
    a_par: assert property (p_par) else $error("parity not odd");
    property p_nar; @(posedge bc) disable iff (!rst_b_i)
        !bus_wide_i |-> rx_cell_bus_word_o[15:8] == 8'h00; endproperty
    a_nar: assert property (p_nar) else $error("upper byte used");
    property p_hold; @(posedge bc) disable iff (!rst_b_i)
        rx_cell_bus_read_enable_n_i |=> $stable({rx_cell_bus_word_o, rx_cell_first_word_flag_o}); endproperty
    a_hold: assert property (p_hold) else $error("word moved unread");
    property p_sel; @(posedge bc) disable iff (!rst_b_i) multi_phy_i && age_reg == 3'h7
        |-> rx_cell_available_oe_o == ($past(rx_phy_select_address_i) == shd_reg[4:0]); endproperty
    a_sel: assert property (p_sel) else $error("select drive wrong");
    property p_acc; @(posedge clk_sys_i) disable iff (!rst_b_i)
        cell_word_valid_i && cell_word_ready_o && cell_word_first_i |=> cell_accepted_pulse_o; endproperty
    a_acc: assert property (p_acc) else $error("no accept pulse");
    property p_rd; @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_map |=> reg_rdata_o == $past(shd_reg); endproperty
    a_rd: assert property (p_rd) else $error("register read wrong");
    property p_rz; @(posedge clk_sys_i) disable iff (!rst_b_i)
        !rd_map |=> reg_rdata_o == 8'h00; endproperty
    a_rz: assert property (p_rz) else $error("read data not zero");
    c_sel: cover property (@(posedge bc) multi_phy_i && rx_cell_available_oe_o);
    c_acc: cover property (@(posedge clk_sys_i) cell_accepted_pulse_o);
    c_first: cover property (@(posedge bc) rx_cell_first_word_flag_o && !rx_cell_bus_read_enable_n_i);
endmodule : arcbp_chk
bind arcbp_top arcbp_chk i_chk (.*);

// >>> arcbp_atm_model.sv
`timescale 1ns/10ps
module arcbp_atm_model (
    // Bus clock and control
    input  wire logic        clk_i, go_i, slow_i,
    input  wire logic [10:0] len_i,
    input  wire logic [4:0]  adr_i,
    // Cell bus
    input  wire logic [15:0] word_i,
    input  wire logic        first_i, clav_i, clav_oe_i, oe_i,
    output logic             en_n_o,
    output logic      [4:0]  addr_o
);
    logic [16:0] got[$];
    logic        tk = 1'b0;
    logic        ph = 1'b0;
    int          cnt = 0;
    initial en_n_o = 1'b1;
    assign addr_o = adr_i;
    always @(posedge clk_i)
    begin
        // A released bus reads back as the inverse of the last word
        if (tk)
            got.push_back({first_i, oe_i ? word_i : ~word_i});
        tk <= !en_n_o;
        ph <= !ph;
        if (cnt != 0)
        begin
            en_n_o <= 1'b0;
            cnt    <= cnt - 1;
        end
        else if (en_n_o && go_i && clav_oe_i && clav_i && (ph || !slow_i))
        begin
            en_n_o <= 1'b0;
            cnt    <= len_i - 11'h001;
        end
        else
            en_n_o <= 1'b1;
    end
endmodule : arcbp_atm_model

// >>> arcbp_tb_top.sv
`timescale 1ns/10ps
module arcbp_tb_top;
    logic        clk_sys_i = 1'b0, rx_cell_bus_clock_i = 1'b0, rst_b_i = 1'b0;
    logic        reg_select_i = 1'b0, reg_write_i = 1'b0, bus_wide_i = 1'b1;
    logic        cell_level_mode_i = 1'b0, multi_phy_i = 1'b0;
    logic        cell_word_first_i = 1'b0, cell_word_valid_i = 1'b0;
    logic [8:0]  reg_addr_i = 9'h000;
    logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
    logic [15:0] cell_word_i = 16'h0000, rx_cell_bus_word_o;
    logic [4:0]  rx_phy_select_address_i, adr = 5'h00;
    logic        rx_cell_bus_read_enable_n_i, cell_word_ready_o, cell_accepted_pulse_o;
    logic        rx_cell_bus_word_oe_o, rx_cell_first_word_flag_o, rx_cell_bus_odd_parity_o;
    logic        rx_cell_available_o, rx_cell_available_oe_o, go = 1'b0, slow = 1'b0;
    logic [10:0] cl, len;
    logic [16:0] ex[$];
    int          error_cnt = 0, num_checks = 0, seed = 32'h3fb9, acc_cnt = 0;
    assign cl  = bus_wide_i ? arcbp_pkg::CELL_WORDS_WIDE : arcbp_pkg::CELL_BYTES_NARROW;
    assign len = (cell_level_mode_i | multi_phy_i) ? cl : 11'h001;
    always #12.5 clk_sys_i = !clk_sys_i;
    always #6 rx_cell_bus_clock_i = !rx_cell_bus_clock_i;
    // Count accepted-cell pulses
    always @(posedge clk_sys_i)
        if (cell_accepted_pulse_o === 1'b1)
            acc_cnt++;
    arcbp_top i_dut (.*);
    arcbp_atm_model i_atm (.clk_i(rx_cell_bus_clock_i), .go_i(go), .slow_i(slow), .len_i(len),
        .adr_i(adr), .word_i(rx_cell_bus_word_o), .first_i(rx_cell_first_word_flag_o),
        .clav_i(rx_cell_available_o), .clav_oe_i(rx_cell_available_oe_o), .oe_i(rx_cell_bus_word_oe_o),
        .en_n_o(rx_cell_bus_read_enable_n_i), .addr_o(rx_phy_select_address_i));
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // One register access; reads compare with d
    task automatic reg_acc(input logic w, input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_select_i <= 1'b1;
        reg_write_i  <= w;
        reg_addr_i   <= a;
        reg_wdata_i  <= d;
        @(posedge clk_sys_i);
        reg_select_i <= 1'b0;
        @(negedge clk_sys_i);
        if (!w)
            chk({9'h000, reg_rdata_o}, {9'h000, d});
    endtask : reg_acc
    // Back-to-back cells of random words
    task automatic push(input int n);
        logic [15:0] w;
        for (int c = 0; c < n * cl; c++)
        begin
            w = 16'($random(seed));
            @(posedge clk_sys_i);
            cell_word_valid_i <= 1'b1;
            cell_word_first_i <= (c % cl == 0);
            cell_word_i       <= w;
            ex.push_back({c % cl == 0, bus_wide_i ? w : {8'h00, w[7:0]}});
        end
        @(posedge clk_sys_i);
        cell_word_valid_i <= 1'b0;
    endtask : push
    task automatic run(input logic w, c, m, input logic [4:0] a, input int n);
        logic [7:0] d;
        int         a0;
        d      = 8'($random(seed));
        d[4:0] = a;
        @(posedge clk_sys_i);
        rst_b_i           <= 1'b0;
        go                <= 1'b0;
        bus_wide_i        <= w;
        cell_level_mode_i <= c;
        multi_phy_i       <= m;
        slow              <= c;
        adr               <= m ? ~a : a;
        repeat (16) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        reg_acc(1'b0, arcbp_pkg::PHY_ADDR_OFS, arcbp_pkg::PHY_ADDR_RST);
        reg_acc(1'b1, arcbp_pkg::PHY_ADDR_OFS, d);
        reg_acc(1'b0, arcbp_pkg::PHY_ADDR_OFS, d);
        reg_acc(1'b0, 9'h0a5, 8'h00);
        a0 = acc_cnt;
        push(n);
        repeat (2) @(posedge clk_sys_i);
        chk(17'(acc_cnt - a0), 17'(n));
        go <= 1'b1;
        if (m)
        begin
            repeat (60) @(posedge clk_sys_i);
            chk(17'(i_atm.got.size()), 17'h00000);
            adr <= a;
        end
        for (int t = 0; t < 5000 && i_atm.got.size() < ex.size(); t++) @(posedge clk_sys_i);
        if (i_atm.got.size() != ex.size())
        begin
            $display("mismatch at %0t: drain timeout", $time);
            error_cnt++;
            ex.delete();
            i_atm.got.delete();
        end
        while (ex.size() > 0)
            chk(i_atm.got.pop_front(), ex.pop_front());
    endtask : run
    initial
    begin
        run(1'b1, 1'b0, 1'b0, 5'h03, 2);
        run(1'b1, 1'b1, 1'b0, 5'h0c, 3);
        run(1'b0, 1'b0, 1'b0, 5'h11, 2);
        run(1'b0, 1'b0, 1'b1, 5'h16, 2);
        wrap_up;
    end
endmodule : arcbp_tb_top
